// ==== shared/lmsc_pkg.sv ====
// Constants, encodings and types for the laser module state control block.
// Assumes a single 100 MHz clock; pins are already synchronous to it.
package lmsc_pkg;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned RESETTING_NS = 1000;
   localparam int unsigned MGMT_INIT_NS = 2000;
   localparam int unsigned PWR_UP_NS = 5000;
   localparam int TMR_W = 10;
   localparam logic [TMR_W-1:0] RESETTING_LAST =
      TMR_W'((RESETTING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [TMR_W-1:0] MGMT_INIT_LAST =
      TMR_W'((MGMT_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [TMR_W-1:0] PWR_UP_LAST =
      TMR_W'((PWR_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [TMR_W-1:0] TMR_ZERO = 10'h000;
   localparam logic [TMR_W-1:0] TMR_ONE = 10'h001;

   // Lasers and management link
   localparam int LASER_CNT = 8;
   localparam logic [LASER_CNT-1:0] LASERS_OFF = 8'h00;
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   // Register offsets on the management link
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CLASS = 8'h01;
   localparam logic [7:0] REG_CTRL = 8'h02;
   localparam logic [7:0] REG_LASER = 8'h03;
   localparam logic [7:0] REG_LASER_ON = 8'h04;
   localparam logic [7:0] RD_NONE = 8'h00;

   // Control register fields
   localparam int CTRL_SW_RESET = 0;
   localparam int CTRL_SW_LOWPWR = 1;
   localparam int CTRL_TEC_EN = 2;
   localparam logic [7:0] CTRL_WMASK = 8'h07;
   localparam logic [7:0] CTRL_RESET = 8'h04;

   // Power classes, maximum power in milliwatts per class
   localparam logic [3:0] CLASS_LOW = 4'h1;
   localparam logic [3:0] CLASS_ABOVE = 4'hA;
   localparam int CLASS_LAST = 9;
   localparam int unsigned CLASS_MAX_MW [1:9] =
      '{1500, 3500, 7000, 8000, 9000, 12000, 15000, 18000, 21000};
   localparam int unsigned MODULE_FULL_MW = 14000;

   // Status codes of the module state
   localparam logic [7:0] CODE_RESETTING = 8'h01;
   localparam logic [7:0] CODE_RESET = 8'h02;
   localparam logic [7:0] CODE_MGMT_INIT = 8'h03;
   localparam logic [7:0] CODE_LOW_PWR = 8'h04;
   localparam logic [7:0] CODE_PWR_UP = 8'h05;
   localparam logic [7:0] CODE_READY = 8'h06;

   typedef enum logic [5:0] {
      LMSC_RESETTING = 6'h01,
      LMSC_RESET = 6'h02,
      LMSC_MGMT_INIT = 6'h04,
      LMSC_LOW_PWR = 6'h08,
      LMSC_PWR_UP = 6'h10,
      LMSC_READY = 6'h20
   } lmsc_state_e;

   typedef enum logic [6:0] {
      LMSC_TW_IDLE = 7'h01,
      LMSC_TW_ADDR = 7'h02,
      LMSC_TW_ACK_A = 7'h04,
      LMSC_TW_WR = 7'h08,
      LMSC_TW_ACK_W = 7'h10,
      LMSC_TW_RD = 7'h20,
      LMSC_TW_ACK_R = 7'h40
   } lmsc_tw_e;
endpackage

// ==== shared/lmsc_mgmt_if.sv ====
// Byte access path between the two-wire engine and the register file.
// Assumes both ends run on mclk; wr_stb is a one-cycle pulse.
`timescale 1ns/10ps
interface lmsc_mgmt_if;
   logic wr_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport eng (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ==== hdl/lmsc_twi.sv ====
// Two-wire management slave: byte pointer, sequential writes and reads.
// Assumes scl and sda_in are synchronous to mclk and far slower than it.
`timescale 1ns/10ps
module lmsc_twi (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic select_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   lmsc_mgmt_if.eng bus
);
   lmsc_pkg::lmsc_tw_e tst, next_tst;
   logic scl_q, sda_q, rw, next_rw, first, next_first, oe, next_oe;
   logic wr, next_wr;
   logic [2:0] cnt, next_cnt;
   logic [7:0] sh, next_sh, ptr, next_ptr, wd, next_wd;
   logic scl_rise, scl_fall, start_c, stop_c;

   assign scl_rise = scl & ~scl_q;
   assign scl_fall = ~scl & scl_q;
   assign start_c = scl & scl_q & sda_q & ~sda_in;
   assign stop_c = scl & scl_q & ~sda_q & sda_in;
   // Open drain: the pin is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = oe;
   assign bus.wr_stb = wr;
   assign bus.addr = ptr;
   assign bus.wdata = wd;

   always_comb begin
      next_tst = tst;
      next_rw = rw;
      next_first = first;
      next_oe = oe;
      next_cnt = cnt;
      next_sh = sh;
      next_wd = wd;
      next_wr = 1'b0;
      // Pointer steps the cycle after a write so the strobe sees the old one
      next_ptr = wr ? ptr + 8'h01 : ptr;
      if (stop_c) begin
         next_tst = lmsc_pkg::LMSC_TW_IDLE;
         next_oe = 1'b0;
      end else if (start_c) begin
         next_tst = lmsc_pkg::LMSC_TW_ADDR;
         next_cnt = lmsc_pkg::BIT_FIRST;
         next_oe = 1'b0;
      end else begin
         case (tst)
            lmsc_pkg::LMSC_TW_ADDR: if (scl_rise) begin
               next_sh = {sh[6:0], sda_in};
               next_cnt = cnt + 3'h1;
               if (cnt == lmsc_pkg::BIT_LAST) begin
                  if (!select_n && sh[6:0] == lmsc_pkg::DEV_ADDR) begin
                     next_tst = lmsc_pkg::LMSC_TW_ACK_A;
                     next_rw = sda_in;
                     next_first = 1'b1;
                  end else begin
                     next_tst = lmsc_pkg::LMSC_TW_IDLE;
                  end
               end
            end
            lmsc_pkg::LMSC_TW_ACK_A, lmsc_pkg::LMSC_TW_ACK_W: if (scl_fall) begin
               if (!oe) begin
                  next_oe = 1'b1;
               end else if (rw) begin
                  next_sh = bus.rdata;
                  next_oe = ~bus.rdata[7];
                  next_cnt = lmsc_pkg::BIT_FIRST;
                  next_ptr = ptr + 8'h01;
                  next_tst = lmsc_pkg::LMSC_TW_RD;
               end else begin
                  next_oe = 1'b0;
                  next_cnt = lmsc_pkg::BIT_FIRST;
                  next_tst = lmsc_pkg::LMSC_TW_WR;
               end
            end
            lmsc_pkg::LMSC_TW_WR: if (scl_rise) begin
               next_sh = {sh[6:0], sda_in};
               next_cnt = cnt + 3'h1;
               if (cnt == lmsc_pkg::BIT_LAST) begin
                  next_tst = lmsc_pkg::LMSC_TW_ACK_W;
                  if (first) begin
                     next_ptr = {sh[6:0], sda_in};
                     next_first = 1'b0;
                  end else begin
                     next_wd = {sh[6:0], sda_in};
                     next_wr = 1'b1;
                  end
               end
            end
            lmsc_pkg::LMSC_TW_RD: if (scl_rise) begin
               next_cnt = cnt + 3'h1;
               if (cnt == lmsc_pkg::BIT_LAST) begin
                  next_tst = lmsc_pkg::LMSC_TW_ACK_R;
               end
            end else if (scl_fall) begin
               next_sh = {sh[6:0], 1'b0};
               next_oe = ~sh[6];
            end
            lmsc_pkg::LMSC_TW_ACK_R: if (scl_fall) begin
               next_oe = 1'b0;
            end else if (scl_rise) begin
               // A master nack ends the read; an ack reuses the load path
               next_tst = sda_in ? lmsc_pkg::LMSC_TW_IDLE : lmsc_pkg::LMSC_TW_ACK_A;
               next_oe = ~sda_in;
            end
            default: next_oe = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tst <= lmsc_pkg::LMSC_TW_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rw <= 1'b0;
         first <= 1'b0;
         oe <= 1'b0;
         wr <= 1'b0;
         cnt <= lmsc_pkg::BIT_FIRST;
         sh <= 8'h00;
         ptr <= 8'h00;
         wd <= 8'h00;
      end else begin
         tst <= next_tst;
         scl_q <= scl;
         sda_q <= sda_in;
         rw <= next_rw;
         first <= next_first;
         oe <= next_oe;
         wr <= next_wr;
         cnt <= next_cnt;
         sh <= next_sh;
         ptr <= next_ptr;
         wd <= next_wd;
      end
   end

   property p_idle_release;
      @(posedge mclk) disable iff (!rstn)
      (tst == lmsc_pkg::LMSC_TW_IDLE) |-> !sda_oe;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("data line driven while link idle");
endmodule

// ==== hdl/lmsc_top.sv ====
// Laser module state control: module state machine, laser gating, side-band pins.
// Assumes pins synchronous to mclk; the host reaches registers over two wires.
`timescale 1ns/10ps
module lmsc_top (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_pin,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic module_present_n,
   output logic [lmsc_pkg::LASER_CNT-1:0] laser_en,
   output logic ld_supply_en,
   output logic tec_en,
   output logic low_power_active,
   output logic [3:0] power_class
);
   lmsc_mgmt_if mif();

   lmsc_pkg::lmsc_state_e st, next_st;
   logic [lmsc_pkg::TMR_W-1:0] tmr, next_tmr;
   logic rr_q;
   logic [7:0] ctrl, next_ctrl;
   logic [lmsc_pkg::LASER_CNT-1:0] mask, next_mask, next_laser;
   logic next_ld, next_tec, next_lpa;
   logic [3:0] next_class;
   logic reset_request, lp_req;

   function automatic logic is_powered(input lmsc_pkg::lmsc_state_e s);
      is_powered = (s == lmsc_pkg::LMSC_PWR_UP) || (s == lmsc_pkg::LMSC_READY);
   endfunction

   function automatic logic [7:0] state_code(input lmsc_pkg::lmsc_state_e s);
      case (s)
         lmsc_pkg::LMSC_RESETTING: state_code = lmsc_pkg::CODE_RESETTING;
         lmsc_pkg::LMSC_RESET: state_code = lmsc_pkg::CODE_RESET;
         lmsc_pkg::LMSC_MGMT_INIT: state_code = lmsc_pkg::CODE_MGMT_INIT;
         lmsc_pkg::LMSC_LOW_PWR: state_code = lmsc_pkg::CODE_LOW_PWR;
         lmsc_pkg::LMSC_PWR_UP: state_code = lmsc_pkg::CODE_PWR_UP;
         default: state_code = lmsc_pkg::CODE_READY;
      endcase
   endfunction

   // Smallest class whose ceiling covers the given draw
   function automatic logic [3:0] class_of(input int unsigned mw);
      class_of = lmsc_pkg::CLASS_ABOVE;
      for (int i = lmsc_pkg::CLASS_LAST; i >= 1; i--) begin
         if (mw <= lmsc_pkg::CLASS_MAX_MW[i]) begin
            class_of = 4'(i);
         end
      end
   endfunction

   lmsc_twi u_twi (
      .mclk(mclk),
      .rstn(rstn),
      .select_n(module_select_n),
      .scl(scl),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .bus(mif.eng)
   );

   assign module_present_n = 1'b0;
   assign reset_request = ~module_reset_n | ctrl[lmsc_pkg::CTRL_SW_RESET];
   assign lp_req = low_power_pin | ctrl[lmsc_pkg::CTRL_SW_LOWPWR];

   // Module state machine
   always_comb begin
      next_st = st;
      next_tmr = tmr + lmsc_pkg::TMR_ONE;
      if (reset_request && !rr_q) begin
         next_st = lmsc_pkg::LMSC_RESETTING;
         next_tmr = lmsc_pkg::TMR_ZERO;
      end else begin
         case (st)
            lmsc_pkg::LMSC_RESETTING: if (tmr == lmsc_pkg::RESETTING_LAST) begin
               next_st = lmsc_pkg::LMSC_RESET;
            end
            lmsc_pkg::LMSC_RESET: begin
               next_tmr = lmsc_pkg::TMR_ZERO;
               if (!reset_request) begin
                  next_st = lmsc_pkg::LMSC_MGMT_INIT;
               end
            end
            lmsc_pkg::LMSC_MGMT_INIT: if (tmr == lmsc_pkg::MGMT_INIT_LAST) begin
               next_st = lmsc_pkg::LMSC_LOW_PWR;
            end
            lmsc_pkg::LMSC_LOW_PWR: begin
               next_tmr = lmsc_pkg::TMR_ZERO;
               if (!lp_req) begin
                  next_st = lmsc_pkg::LMSC_PWR_UP;
               end
            end
            lmsc_pkg::LMSC_PWR_UP: begin
               // Coolers settle here before any laser may start
               if (lp_req) begin
                  next_st = lmsc_pkg::LMSC_LOW_PWR;
               end else if (tmr == lmsc_pkg::PWR_UP_LAST) begin
                  next_st = lmsc_pkg::LMSC_READY;
               end
            end
            lmsc_pkg::LMSC_READY: if (lp_req) begin
               next_st = lmsc_pkg::LMSC_LOW_PWR;
            end
            default: next_st = lmsc_pkg::LMSC_RESETTING;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st <= lmsc_pkg::LMSC_RESETTING;
         tmr <= lmsc_pkg::TMR_ZERO;
         rr_q <= 1'b0;
      end else begin
         st <= next_st;
         tmr <= next_tmr;
         rr_q <= reset_request;
      end
   end

   // Registers written by the host
   always_comb begin
      next_ctrl = ctrl;
      next_mask = mask;
      if (st == lmsc_pkg::LMSC_RESETTING) begin
         next_ctrl = lmsc_pkg::CTRL_RESET;
         next_mask = lmsc_pkg::LASERS_OFF;
      end else begin
         // A command only counts once ready; it is forgotten on leaving
         if (st != lmsc_pkg::LMSC_READY) begin
            next_mask = lmsc_pkg::LASERS_OFF;
         end
         if (mif.wr_stb) begin
            case (mif.addr)
               lmsc_pkg::REG_CTRL: next_ctrl = mif.wdata & lmsc_pkg::CTRL_WMASK;
               lmsc_pkg::REG_LASER: if (st == lmsc_pkg::LMSC_READY) begin
                  next_mask = mif.wdata;
               end
               default: next_ctrl = ctrl;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= lmsc_pkg::CTRL_RESET;
         mask <= lmsc_pkg::LASERS_OFF;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
      end
   end

   // Read side of the management link
   always_comb begin
      case (mif.addr)
         lmsc_pkg::REG_STATUS: mif.rdata = state_code(st);
         lmsc_pkg::REG_CLASS: mif.rdata = {4'h0, power_class};
         lmsc_pkg::REG_CTRL: mif.rdata = ctrl;
         lmsc_pkg::REG_LASER: mif.rdata = mask;
         lmsc_pkg::REG_LASER_ON: mif.rdata = laser_en;
         default: mif.rdata = lmsc_pkg::RD_NONE;
      endcase
   end

   // Power gating outputs
   always_comb begin
      next_laser = lmsc_pkg::LASERS_OFF;
      if (st == lmsc_pkg::LMSC_READY && !lp_req && !reset_request) begin
         next_laser = mask;
      end
      next_ld = (st == lmsc_pkg::LMSC_READY) && !lp_req;
      next_tec = is_powered(st) && !lp_req && ctrl[lmsc_pkg::CTRL_TEC_EN];
      next_lpa = !is_powered(st);
      next_class = is_powered(st) ? class_of(lmsc_pkg::MODULE_FULL_MW) : lmsc_pkg::CLASS_LOW;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         laser_en <= lmsc_pkg::LASERS_OFF;
         ld_supply_en <= 1'b0;
         tec_en <= 1'b0;
         low_power_active <= 1'b1;
         power_class <= lmsc_pkg::CLASS_LOW;
      end else begin
         laser_en <= next_laser;
         ld_supply_en <= next_ld;
         tec_en <= next_tec;
         low_power_active <= next_lpa;
         power_class <= next_class;
      end
   end

   property p_ins_off;
      @(posedge mclk) disable iff (!rstn)
      (st == lmsc_pkg::LMSC_RESETTING) |=> (laser_en == lmsc_pkg::LASERS_OFF);
   endproperty
   a_ins_off: assert property (p_ins_off)
      else $error("laser on after resetting");

   property p_held_after;
      @(posedge mclk) disable iff (!rstn)
      $rose(st == lmsc_pkg::LMSC_RESET) |-> $past(st == lmsc_pkg::LMSC_RESETTING);
   endproperty
   a_held_after: assert property (p_held_after)
      else $error("reset-held not entered from resetting");

   property p_held_wait;
      @(posedge mclk) disable iff (!rstn)
      (st == lmsc_pkg::LMSC_RESET) ##0 !reset_request |=> (st == lmsc_pkg::LMSC_MGMT_INIT);
   endproperty
   a_held_wait: assert property (p_held_wait)
      else $error("reset-held did not advance");

   property p_init_to_lp;
      @(posedge mclk) disable iff (!rstn)
      $fell(st == lmsc_pkg::LMSC_MGMT_INIT) |->
         (st == lmsc_pkg::LMSC_LOW_PWR) || (st == lmsc_pkg::LMSC_RESETTING);
   endproperty
   a_init_to_lp: assert property (p_init_to_lp)
      else $error("init left to wrong state");

   property p_lp_pin_off;
      @(posedge mclk) disable iff (!rstn)
      low_power_pin |=> (laser_en == lmsc_pkg::LASERS_OFF) && !ld_supply_en;
   endproperty
   a_lp_pin_off: assert property (p_lp_pin_off)
      else $error("laser powered in low power");

   property p_need_ready;
      @(posedge mclk) disable iff (!rstn)
      (laser_en != lmsc_pkg::LASERS_OFF) |->
         $past(st == lmsc_pkg::LMSC_READY) && $past(mask != lmsc_pkg::LASERS_OFF);
   endproperty
   a_need_ready: assert property (p_need_ready)
      else $error("laser on without ready and command");

   property p_host_only;
      @(posedge mclk) disable iff (!rstn)
      $changed(mask) && (mask != lmsc_pkg::LASERS_OFF) |->
         $past(mif.wr_stb && mif.addr == lmsc_pkg::REG_LASER);
   endproperty
   a_host_only: assert property (p_host_only)
      else $error("laser command not from host write");

   property p_lp_state;
      @(posedge mclk) disable iff (!rstn)
      (st == lmsc_pkg::LMSC_LOW_PWR) |=>
         low_power_active && !tec_en && (power_class == lmsc_pkg::CLASS_LOW);
   endproperty
   a_lp_state: assert property (p_lp_state)
      else $error("low power state not minimal");

   property p_ready_order;
      @(posedge mclk) disable iff (!rstn)
      $rose(st == lmsc_pkg::LMSC_READY) |-> $past(st == lmsc_pkg::LMSC_PWR_UP, 1);
   endproperty
   a_ready_order: assert property (p_ready_order)
      else $error("ready not reached through power-up");

   property p_reset_pin;
      @(posedge mclk) disable iff (!rstn)
      $fell(module_reset_n) |=> (st == lmsc_pkg::LMSC_RESETTING) ##1
         (laser_en == lmsc_pkg::LASERS_OFF);
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("reset pin did not restart");

   property p_present;
      @(posedge mclk) disable iff (!rstn)
      $rose(ld_supply_en) |-> !module_present_n && !low_power_active;
   endproperty
   a_present: assert property (p_present)
      else $error("present pin not low while powered");
endmodule

// ==== testbench/lmsc_host_model.sv ====
// Host controller model: makes the two-wire clock and pulls the data line low.
// Assumes the device answers within a 20-cycle bit; the data line has a pull-up.
`timescale 1ns/10ps
module lmsc_host_model (
   input wire logic mclk,
   input wire logic dev_oe,
   input wire logic dev_out,
   output logic scl,
   output logic sda_line
);
   logic host_low = 1'b0;
   initial scl = 1'b1;
   // Pull-up: a released line reads high, never the last value
   assign sda_line = ~host_low & ~(dev_oe & ~dev_out);
   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Data changes only while the clock is low; sampled mid-high
   task automatic clk_bit(input logic b, output logic s);
      host_low = ~b;
      hold(5);
      scl = 1'b1;
      hold(5);
      s = sda_line;
      hold(5);
      scl = 1'b0;
      hold(5);
   endtask
   task automatic start();
      scl = 1'b1;
      hold(5);
      host_low = 1'b1;
      hold(5);
      scl = 1'b0;
      hold(5);
   endtask
   task automatic stop();
      host_low = 1'b1;
      hold(5);
      scl = 1'b1;
      hold(5);
      host_low = 1'b0;
      hold(5);
   endtask
   // Ninth bit is released: ack on writes, nack from the host on reads
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
      clk_bit(1'b1, a);
      ack = ~a;
   endtask
   // Only this model issues register writes, laser commands included
   task automatic access(input logic rd, input logic [7:0] off, input logic [7:0] wd,
                         output logic [7:0] rdv, output logic ok);
      logic a1, a2, a3, x;
      logic [7:0] junk;
      start();
      xfer({lmsc_pkg::DEV_ADDR, 1'b0}, junk, a1);
      xfer(off, junk, a2);
      rdv = 8'h00;
      if (rd) begin
         start();
         xfer({lmsc_pkg::DEV_ADDR, 1'b1}, junk, a3);
         xfer(8'hFF, rdv, x);
      end else begin
         xfer(wd, junk, a3);
      end
      stop();
      ok = a1 & a2 & a3;
   endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the laser module state control block.
// Assumes the host model file is compiled first; no other partner.
`timescale 1ns/10ps
module tb_top;
   logic mclk, rstn, module_reset_n, module_select_n, low_power_pin, ok;
   logic scl, sda_line, sda_out, sda_oe, module_present_n, ld_supply_en, tec_en;
   logic low_power_active;
   logic [lmsc_pkg::LASER_CNT-1:0] laser_en;
   logic [3:0] power_class, cls;
   logic [7:0] rd_val, m;
   logic [16:0] exp_q[$];
   event ev;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   wire [15:0] outs = {laser_en, ld_supply_en, tec_en, low_power_active, power_class,
                       module_present_n};

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   lmsc_top dut (.mclk(mclk), .rstn(rstn), .module_reset_n(module_reset_n),
      .module_select_n(module_select_n), .low_power_pin(low_power_pin), .scl(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .module_present_n(module_present_n), .laser_en(laser_en),
      .ld_supply_en(ld_supply_en), .tec_en(tec_en), .low_power_active(low_power_active),
      .power_class(power_class));
   lmsc_host_model host (.mclk(mclk), .dev_oe(sda_oe), .dev_out(sda_out), .scl(scl),
      .sda_line(sda_line));

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic note(input logic [16:0] e);
      exp_q.push_back(e);
      ->ev;
   endtask
   // Present pin is always expected low
   function automatic logic [16:0] o(input logic [7:0] l, input logic ld, input logic tec,
                                     input logic lp, input logic [3:0] c);
      return {1'b0, l, ld, tec, lp, c, 1'b0};
   endfunction
   // Writes report the ack as the result, reads the data byte
   task automatic acc(input logic rd, input logic [7:0] off, input logic [7:0] wd,
                      input logic [7:0] e);
      host.access(rd, off, wd, rd_val, ok);
      if (!rd) rd_val = {7'h00, ok};
      note({9'h100, e});
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   initial begin
      logic [16:0] e;
      // Drain all notes: two notes in one time step raise only one wake-up
      forever begin
         @(ev);
         while (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            check(e[16] ? {8'h00, rd_val} : outs, e[15:0]);
         end
      end
   end

   // Each transfer is under 800 cycles; the whole run stays near 15000
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch = n_mismatch + 1;
         final_report();
      end
   end

   initial begin
      cls = 4'h0;
      for (int i = 1; i <= lmsc_pkg::CLASS_LAST; i++)
         if (cls == 4'h0 && lmsc_pkg::MODULE_FULL_MW <= lmsc_pkg::CLASS_MAX_MW[i]) cls = 4'(i);
      void'($urandom(90633));
      rstn = 1'b0;
      module_reset_n = 1'b0;
      module_select_n = 1'b0;
      low_power_pin = 1'b1;
      wait_cyc(8);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      rstn = 1'b1;
      wait_cyc(150);
      acc(1'b1, lmsc_pkg::REG_STATUS, 8'h00, lmsc_pkg::CODE_RESET);
      acc(1'b1, lmsc_pkg::REG_CTRL, 8'h00, lmsc_pkg::CTRL_RESET);
      module_reset_n = 1'b1;
      wait_cyc(400);
      acc(1'b1, lmsc_pkg::REG_STATUS, 8'h00, lmsc_pkg::CODE_LOW_PWR);
      acc(1'b0, lmsc_pkg::REG_LASER, 8'hFF, 8'h01);
      acc(1'b1, lmsc_pkg::REG_LASER_ON, 8'h00, 8'h00);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      low_power_pin = 1'b0;
      wait_cyc(10);
      note(o(8'h00, 1'b0, 1'b1, 1'b0, cls));
      wait_cyc(600);
      note(o(8'h00, 1'b1, 1'b1, 1'b0, cls));
      acc(1'b1, lmsc_pkg::REG_STATUS, 8'h00, lmsc_pkg::CODE_READY);
      acc(1'b1, lmsc_pkg::REG_CLASS, 8'h00, {4'h0, cls});
      acc(1'b1, 8'h10, 8'h00, lmsc_pkg::RD_NONE);
      m = 8'($urandom);
      acc(1'b0, lmsc_pkg::REG_LASER, m, 8'h01);
      wait_cyc(3);
      note(o(m, 1'b1, 1'b1, 1'b0, cls));
      acc(1'b1, lmsc_pkg::REG_LASER_ON, 8'h00, m);
      module_select_n = 1'b1;
      acc(1'b0, lmsc_pkg::REG_LASER, ~m, 8'h00);
      module_select_n = 1'b0;
      note(o(m, 1'b1, 1'b1, 1'b0, cls));
      low_power_pin = 1'b1;
      wait_cyc(3);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      low_power_pin = 1'b0;
      wait_cyc(600);
      note(o(8'h00, 1'b1, 1'b1, 1'b0, cls));
      acc(1'b0, lmsc_pkg::REG_CTRL, 8'h06, 8'h01);
      wait_cyc(3);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      acc(1'b0, lmsc_pkg::REG_CTRL, 8'h04, 8'h01);
      wait_cyc(600);
      acc(1'b0, lmsc_pkg::REG_CTRL, 8'h05, 8'h01);
      wait_cyc(3);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      acc(1'b1, lmsc_pkg::REG_CTRL, 8'h00, lmsc_pkg::CTRL_RESET);
      acc(1'b0, lmsc_pkg::REG_LASER, 8'hA5, 8'h01);
      wait_cyc(3);
      note(o(8'hA5, 1'b1, 1'b1, 1'b0, cls));
      module_reset_n = 1'b0;
      wait_cyc(2);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      wait_cyc(200);
      acc(1'b1, lmsc_pkg::REG_STATUS, 8'h00, lmsc_pkg::CODE_RESET);
      acc(1'b1, lmsc_pkg::REG_LASER, 8'h00, 8'h00);
      rstn = 1'b0;
      wait_cyc(2);
      note(o(8'h00, 1'b0, 1'b0, 1'b1, lmsc_pkg::CLASS_LOW));
      rstn = 1'b1;
      wait_cyc(2);
      final_report();
   end
endmodule
